//--- common/pic_pkg.sv
// package of constants, types and state layout for the interval counter
package pic_pkg;

   // ****************************************
   // widths and register offsets
   // ****************************************
   localparam int ADDR_W = 4;                  // register address width
   localparam int DATA_W = 8;                  // register data width
   localparam int CNT_W = 16;                  // counting element width
   localparam logic [3:0] OFF_CTRL = 4'h0;     // control word, write only
   localparam logic [3:0] OFF_COUNT = 4'h1;    // initial count bytes, write
   localparam logic [3:0] OFF_STATUS = 4'h2;   // status, read only
   localparam logic [3:0] OFF_CE_LO = 4'h3;    // counting element low byte
   localparam logic [3:0] OFF_CE_HI = 4'h4;    // counting element high byte

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int CW_MODE_LSB = 1;             // control word mode field
   localparam int CW_RW_LSB = 4;               // control word byte format
   localparam logic [15:0] CE_RST = 16'h0000;  // counting element reset
   localparam logic [7:0] BYTE_RST = 8'h00;    // latch and read data reset
   localparam logic [15:0] CE_ONE = 16'h0001;  // terminal compare value

   // ****************************************
   // enumerations
   // ****************************************
   typedef enum logic [2:0] {
      MODE_TERM = 3'b000,                      // interrupt on terminal count
      MODE_ONESHOT = 3'b001,                   // retriggerable one-shot
      MODE_RATE = 3'b010,                      // rate generator
      MODE_SQUARE = 3'b011,                    // square wave generator
      MODE_SWSTB = 3'b100,                     // software strobe
      MODE_HWSTB = 3'b101                      // hardware strobe
   } mode_t;

   typedef enum logic [1:0] {
      RW_LATCH = 2'b00,                        // latch command, ignored here
      RW_LOW = 2'b01,                          // low byte only
      RW_HIGH = 2'b10,                         // high byte only
      RW_BOTH = 2'b11                          // low then high byte
   } rw_t;

   // ****************************************
   // whole state of the counter channel
   // ****************************************
   typedef struct packed {
      mode_t mode;                             // operating mode
      rw_t rw;                                 // count byte format
      logic [7:0] count_low_latch;             // initial count low byte
      logic [7:0] count_high_latch;            // initial count high byte
      logic [15:0] ce;                         // counting element
      logic [15:0] period;                     // count last loaded in modes 2 and 3
      logic byte_hi;                           // next byte is high byte
      logic count_ready;                       // initial count present
      logic load_pending;                      // written count awaits load
      logic running;                           // counting element active
      logic null_count;                        // latch not yet loaded
      logic trig_flag;                         // gate rising edge seen
      logic clk_prev;                          // count clock last sample
      logic gate_prev;                         // gate last sample
      logic out;                               // counter output
      logic [7:0] rdata;                       // read data register
   } state_t;

   localparam state_t STATE_RST = '{
      mode: MODE_TERM, rw: RW_LOW, count_low_latch: BYTE_RST,
      count_high_latch: BYTE_RST, ce: CE_RST, period: CE_RST,
      byte_hi: 1'b0, count_ready: 1'b0, load_pending: 1'b0,
      running: 1'b0, null_count: 1'b0, trig_flag: 1'b0,
      clk_prev: 1'b0, gate_prev: 1'b0, out: 1'b0, rdata: BYTE_RST};

endpackage

//--- rtl/programmable_interval_counter.sv
// one 16-bit down-counting interval timer channel with six modes
`timescale 1ns/1ps
//
// Function
// R1: gate rising edge triggers; load copies 16-bit latch
// R2: all six modes supported on this channel
// R3: mode 0 output low until zero reached
// R4: mode 0 counts only while gate high
// R5: mode 0 load pulse does not decrement
// R6: mode 0 new count reloads next pulse
// R7: mode 0 gate-low count still loads
// R8: mode 1 trigger drives output low N pulses
// R9: mode 1 retrigger reloads; new count waits
// R10: mode 2 output low one pulse per N
// R11: host never writes count one in mode 2
// R12: mode 2 gate low forces high; trigger reloads
// R13: mode 2 new count loads at cycle end
// R14: mode 3 like mode 2, half-high output
// R15: mode 3 odd count high one longer
// R16: mode 4 strobe on expiry; gate pauses only
// R17: mode 4 strobe N+1 pulses after write
// R18: mode 4 rewrite reloads on next pulse
// R19: mode 5 trigger loads; strobe after N+1
// R20: mode 5 only trigger reloads from latches
// R21: host writes control word first, then bytes
// R22: gate level sampled at count clock edge
// R23: gate edge flag sampled then cleared
// R24: decrement by one when enabled, not loading
module programmable_interval_counter
   import pic_pkg::*;
(
   input wire logic clk,                     // system clock, 100 MHz
   input wire logic rstn,                    // async reset, active low
   input wire logic [ADDR_W-1:0] addr,       // register address
   input wire logic [DATA_W-1:0] wdata,      // register write data
   input wire logic wr_stb,                  // write strobe
   input wire logic rd_stb,                  // read strobe
   output logic [DATA_W-1:0] rdata,          // read data, next cycle
   input wire logic count_clock_in,          // count clock, sampled
   input wire logic gate_input,              // gate, sampled
   output logic counter_output               // counter output
);

   // ****************************************
   // decoding helpers
   // ****************************************

   // undefined upper mode codes fold onto rate and square wave
   function automatic mode_t decode_mode(input logic [2:0] code);
      mode_t m;
      case (code)
         3'b110: m = MODE_RATE;
         3'b111: m = MODE_SQUARE;
         default: m = mode_t'(code);
      endcase
      return m;
   endfunction

   // modes whose gate edge is remembered in the trigger flag
   function automatic logic edge_mode(input mode_t m);
      return (m == MODE_ONESHOT) || (m == MODE_RATE) ||
         (m == MODE_SQUARE) || (m == MODE_HWSTB);
   endfunction

   // ****************************************
   // state and next state
   // ****************************************
   state_t s;          // registered state
   state_t next_s;     // next state
   logic cnt_pulse;    // count clock rising edge seen this cycle
   logic gate_rise;    // gate rising edge seen this cycle
   logic trig;         // trigger taken at this count pulse
   logic [15:0] latch; // full initial count
   logic [15:0] dec;   // counting element minus one
   logic periodic;     // rate or square wave mode
   logic [7:0] cw_mode_bits; // shifted control word view

   assign cnt_pulse = count_clock_in & ~s.clk_prev;
   assign gate_rise = gate_input & ~s.gate_prev;   // R1
   assign trig = cnt_pulse & s.trig_flag;          // R23
   assign latch = {s.count_high_latch, s.count_low_latch}; // R1
   assign dec = s.ce - CE_ONE;
   assign periodic = (s.mode == MODE_RATE) || (s.mode == MODE_SQUARE);
   assign cw_mode_bits = wdata >> CW_MODE_LSB;

   // ****************************************
   // next state: counting, then bus access
   // ****************************************
   always_comb begin
      next_s = s;
      next_s.clk_prev = count_clock_in;
      next_s.gate_prev = gate_input;
      // new edge wins over the clear made by sampling
      next_s.trig_flag = (s.trig_flag & ~cnt_pulse) |
         (gate_rise & edge_mode(s.mode)); // R23

      // counting element, one step per count pulse
      if (cnt_pulse) begin
         case (s.mode)
            MODE_TERM: begin
               if (s.load_pending) begin
                  next_s.ce = latch; // R5 R6 R7
                  next_s.load_pending = 1'b0;
                  next_s.null_count = 1'b0;
                  next_s.running = 1'b1;
               end else if (s.running && gate_input) begin
                  next_s.ce = dec; // R4 R22 R24
                  if (s.ce == CE_ONE) begin
                     next_s.out = 1'b1; // R3
                  end
               end
            end
            MODE_ONESHOT: begin
               if (trig && s.count_ready) begin
                  // retrigger also picks up a newer count
                  next_s.ce = latch; // R8 R9
                  next_s.load_pending = 1'b0;
                  next_s.null_count = 1'b0;
                  next_s.running = 1'b1;
                  next_s.out = 1'b0; // R8
               end else if (s.running) begin
                  next_s.ce = dec; // R24
                  if (s.ce == CE_ONE) begin
                     next_s.out = 1'b1; // R8
                     next_s.running = 1'b0;
                  end
               end
            end
            MODE_RATE, MODE_SQUARE: begin
               if (s.count_ready &&
                  (trig || (s.load_pending && !s.running))) begin
                  next_s.ce = latch; // R12
                  next_s.period = latch;
                  next_s.load_pending = 1'b0;
                  next_s.null_count = 1'b0;
                  next_s.running = 1'b1;
               end else if (s.running && gate_input) begin
                  if (s.ce == CE_ONE) begin
                     // cycle end takes any newer count
                     next_s.ce = latch; // R10 R13
                     next_s.period = latch;
                     next_s.load_pending = 1'b0;
                     next_s.null_count = 1'b0;
                  end else begin
                     next_s.ce = dec; // R24
                  end
               end
               if (s.mode == MODE_RATE) begin
                  next_s.out = !(next_s.running &&
                     next_s.ce == CE_ONE); // R10
               end else begin
                  // values N..1: high while above half, odd N high longer
                  next_s.out = !next_s.running ||
                     (next_s.ce > (next_s.period >> 1)); // R14 R15
               end
            end
            MODE_SWSTB: begin
               if (s.load_pending) begin
                  next_s.ce = latch; // R17 R18
                  next_s.load_pending = 1'b0;
                  next_s.null_count = 1'b0;
                  next_s.running = 1'b1;
                  next_s.out = 1'b1;
               end else if (!s.out) begin
                  next_s.out = 1'b1; // R16
                  next_s.running = 1'b0;
               end else if (s.running && gate_input) begin
                  next_s.ce = dec; // R16 R22 R24
                  if (s.ce == CE_ONE) begin
                     next_s.out = 1'b0; // R16 R17
                  end
               end
            end
            MODE_HWSTB: begin
               if (trig && s.count_ready) begin
                  next_s.ce = latch; // R19 R20
                  next_s.load_pending = 1'b0;
                  next_s.null_count = 1'b0;
                  next_s.running = 1'b1;
                  next_s.out = 1'b1;
               end else if (!s.out) begin
                  next_s.out = 1'b1; // R19
                  next_s.running = 1'b0;
               end else if (s.running && gate_input) begin
                  next_s.ce = dec; // R24
                  if (s.ce == CE_ONE) begin
                     next_s.out = 1'b0; // R19
                  end
               end
            end
            default: begin
               next_s.out = 1'b1;
            end
         endcase
      end

      // low gate forces the output high at once, between pulses too
      if (periodic && !gate_input) begin
         next_s.out = 1'b1; // R12 R14
      end

      // control word write: byte format zero is a latch command, ignored
      if (wr_stb && addr == OFF_CTRL &&
         rw_t'(wdata[CW_RW_LSB+1:CW_RW_LSB]) != RW_LATCH) begin
         next_s.mode = decode_mode(cw_mode_bits[2:0]); // R2 R21
         next_s.rw = rw_t'(wdata[CW_RW_LSB+1:CW_RW_LSB]);
         next_s.byte_hi = 1'b0;
         next_s.count_ready = 1'b0;
         next_s.load_pending = 1'b0;
         next_s.running = 1'b0;
         next_s.null_count = 1'b1;
         next_s.trig_flag = 1'b0;
         // only mode 0 starts low
         next_s.out = (decode_mode(cw_mode_bits[2:0]) != MODE_TERM); // R3
      end

      // count write: complete once the format's last byte is in
      if (wr_stb && addr == OFF_COUNT) begin
         case (s.rw)
            RW_LOW: begin
               next_s.count_low_latch = wdata;
               next_s.count_high_latch = BYTE_RST;
            end
            RW_HIGH: begin
               next_s.count_high_latch = wdata;
               next_s.count_low_latch = BYTE_RST;
            end
            RW_BOTH: begin
               if (!s.byte_hi) begin
                  next_s.count_low_latch = wdata;
               end else begin
                  next_s.count_high_latch = wdata;
               end
               next_s.byte_hi = !s.byte_hi; // R21
            end
            default: begin
               next_s.byte_hi = 1'b0;
            end
         endcase
         if (s.rw != RW_BOTH || s.byte_hi) begin
            next_s.count_ready = 1'b1;
            next_s.load_pending = 1'b1; // R5 R6 R13 R17
            next_s.null_count = 1'b1;
            if (s.mode == MODE_TERM) begin
               next_s.out = 1'b0; // R3
            end
         end
      end

      // read data appears the cycle after the strobe; unmapped reads zero
      next_s.rdata = BYTE_RST;
      if (rd_stb) begin
         case (addr)
            OFF_STATUS: next_s.rdata =
               {s.out, s.null_count, s.rw, s.mode, 1'b0};
            OFF_CE_LO: next_s.rdata = s.ce[7:0];
            OFF_CE_HI: next_s.rdata = s.ce[15:8];
            default: next_s.rdata = BYTE_RST;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign counter_output = s.out;

   // ****************************************
   // assertions and covers
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic ctrl_wr; // valid control word write
   assign ctrl_wr = wr_stb && addr == OFF_CTRL &&
      wdata[CW_RW_LSB+1:CW_RW_LSB] != 2'b00;

   a_mode0_ctrl_low: assert property ( // R3
      ctrl_wr && cw_mode_bits[2:0] == 3'b000 |=> !counter_output)
      else $error("mode 0 control write did not drive output low");

   a_mode0_gate_hold: assert property ( // R4
      s.mode == MODE_TERM && cnt_pulse && s.running && !gate_input &&
      !s.load_pending && !wr_stb |=> s.ce == $past(s.ce))
      else $error("mode 0 counted with gate low");

   a_mode0_load_nodec: assert property ( // R5
      s.mode == MODE_TERM && cnt_pulse && s.load_pending && !wr_stb
      |=> s.ce == $past(latch) && !s.null_count)
      else $error("mode 0 load pulse did not load the latch");

   a_step_dec_one: assert property ( // R24
      s.mode == MODE_SWSTB && cnt_pulse && s.running && s.out &&
      gate_input && !s.load_pending && !wr_stb
      |=> s.ce == $past(s.ce) - CE_ONE)
      else $error("counting element did not step by one");

   a_oneshot_trig_low: assert property ( // R8
      s.mode == MODE_ONESHOT && trig && s.count_ready && !wr_stb
      |=> !counter_output && s.ce == $past(latch))
      else $error("one-shot trigger did not start the pulse");

   a_gate_force_high: assert property ( // R12
      periodic && !gate_input && !wr_stb |=> counter_output)
      else $error("low gate did not force output high");

   a_strobe_one_pulse: assert property ( // R16
      s.mode == MODE_SWSTB && !counter_output && cnt_pulse &&
      !s.load_pending && !wr_stb |=> counter_output)
      else $error("strobe stayed low past one count pulse");

   a_trig_flag_clear: assert property ( // R23
      cnt_pulse && s.trig_flag && !gate_rise && !ctrl_wr
      |=> !s.trig_flag)
      else $error("trigger flag not cleared after sampling");

   a_status_read: assert property (
      rd_stb && addr == OFF_STATUS |=> rdata[7] == $past(s.out))
      else $error("status read did not show the output");

   // reload, expiry and strobe paths
   // every mode but 0 starts high
   a_ctrl_out_high: assert property ( // R8 R10 R14 R16 R19
      ctrl_wr && cw_mode_bits[2:0] != 3'b000 |=> counter_output)
      else $error("control write did not drive output high");

   // cycle end reloads; later counts wait for it
   a_rate_cycle_reload: assert property ( // R10 R13
      s.mode == MODE_RATE && cnt_pulse && s.running && gate_input &&
      s.ce == CE_ONE && !s.trig_flag && !wr_stb
      |=> s.ce == $past(latch))
      else $error("rate cycle end did not reload the count");

   a_hwstb_wait_trig: assert property ( // R19 R20
      s.mode == MODE_HWSTB && cnt_pulse && !s.running && !s.trig_flag &&
      !wr_stb |=> s.ce == $past(s.ce))
      else $error("hardware strobe counted without a trigger");

   a_swstb_load_high: assert property ( // R17 R18
      s.mode == MODE_SWSTB && cnt_pulse && s.load_pending && !wr_stb
      |=> s.ce == $past(latch) && counter_output)
      else $error("software strobe load did not take the latch");

   a_oneshot_expire: assert property ( // R8
      s.mode == MODE_ONESHOT && cnt_pulse && s.running &&
      s.ce == CE_ONE && !s.trig_flag && !wr_stb
      |=> counter_output && !s.running)
      else $error("one-shot pulse did not end at zero");

   // low gate freezes count and output
   a_swstb_gate_hold: assert property ( // R16
      s.mode == MODE_SWSTB && cnt_pulse && s.out && !gate_input &&
      !s.load_pending && !wr_stb
      |=> s.ce == $past(s.ce) && counter_output)
      else $error("software strobe moved with gate low");

   c_mode0_expire: cover property (
      s.mode == MODE_TERM && !counter_output ##1 counter_output);
   c_rate_low: cover property (
      s.mode == MODE_RATE && $fell(counter_output));
   c_square_toggle: cover property (
      s.mode == MODE_SQUARE && $rose(counter_output));
   c_hw_strobe: cover property (
      s.mode == MODE_HWSTB && $fell(counter_output));
   c_oneshot_pulse: cover property (
      s.mode == MODE_ONESHOT && $fell(counter_output));

endmodule

//--- dv/pic_host.sv
// host processor model driving the counter register port
`timescale 1ns/1ps
module pic_host
   import pic_pkg::*;
(
   input wire logic clk,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] wdata,
   output logic wr_stb,
   output logic rd_stb,
   input wire logic [DATA_W-1:0] rdata
);
   // idle bus at time zero, strobes low
   initial begin
      addr = 4'h0;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // one-cycle write; data inverted after so stale bytes never match
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      wdata <= ~d;
   endtask

   // one-cycle read; data taken at the edge after the strobe cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   // control word always first, then the low byte it announces, skipped for count one in rate mode
   task automatic setup(input mode_t m, input logic [7:0] n);
      wr(OFF_CTRL, {2'b10, RW_LOW, m, 1'b0});
      if (!(m == MODE_RATE && n == 8'h01)) begin
         wr(OFF_COUNT, n);
      end
   endtask
endmodule

//--- dv/programmable_interval_counter_bench.sv
// self-checking bench for the interval counter channel
`timescale 1ns/1ps
module programmable_interval_counter_bench
   import pic_pkg::*;
;
`define check(what, exp, got) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("mismatch %s expected %0h seen %0h", what, exp, got); \
   end \
end
   // ****************************************
   // clock, reset and wiring
   // ****************************************
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic count_clock_in = 1'b0; // count clock, idle low
   logic gate_input = 1'b1; // gate, enabled by default
   logic counter_output;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic wr_stb, rd_stb;
   logic [7:0] d; // last read byte
   int n_errors = 0;
   int samples_checked = 0;

   always #5 clk = ~clk;

   pic_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata));

   programmable_interval_counter DUT (.clk(clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
      .count_clock_in(count_clock_in), .gate_input(gate_input),
      .counter_output(counter_output));

   // ****************************************
   // shared helpers
   // ****************************************
   // k count pulses, high one sample, low two samples
   task automatic pulses(input int k);
      repeat (k) begin
         @(posedge clk) count_clock_in <= 1'b1;
         @(posedge clk) count_clock_in <= 1'b0;
         @(posedge clk);
      end
   endtask

   // gate low then high: one rising edge
   task automatic trigger();
      @(posedge clk) gate_input <= 1'b0;
      @(posedge clk) gate_input <= 1'b1;
      @(posedge clk);
   endtask

   // counts low output samples, one taken after each of k pulses
   task automatic lows(input int k, input int exp);
      int n;
      n = 0;
      repeat (k) begin
         pulses(1);
         if (counter_output === 1'b0) n++;
      end
      `check("low samples", exp, n)
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   // terminal count: load pulse, N+1 rule, reload, status, reads
   task automatic t_mode0();
      host.setup(MODE_TERM, 8'h02);
      host.rd(OFF_STATUS, d);
      `check("status", 8'h50, d)
      pulses(1);
      host.rd(OFF_CE_LO, d);
      `check("ce low", 8'h02, d)
      host.rd(OFF_CE_HI, d);
      `check("ce high", 8'h00, d)
      host.rd(4'hf, d);
      `check("unmapped", 8'h00, d)
      pulses(1);
      `check("out m0", 1'b0, counter_output)
      pulses(1);
      `check("out m0", 1'b1, counter_output)
      pulses(2);
      `check("out m0 held", 1'b1, counter_output)
      host.wr(OFF_COUNT, 8'h03);
      pulses(1);
      host.rd(OFF_CE_LO, d);
      `check("ce reload", 8'h03, d)
      pulses(2);
      `check("out m0", 1'b0, counter_output)
      pulses(1);
      `check("out m0", 1'b1, counter_output)
   endtask

   // terminal count with gate low: loads, holds, then N pulses
   task automatic t_gate0();
      @(posedge clk) gate_input <= 1'b0;
      host.wr(OFF_COUNT, 8'h02);
      pulses(4);
      host.rd(OFF_CE_LO, d);
      `check("ce gated", 8'h02, d)
      `check("out gated", 1'b0, counter_output)
      @(posedge clk) gate_input <= 1'b1;
      pulses(1);
      `check("out m0", 1'b0, counter_output)
      pulses(1);
      `check("out m0", 1'b1, counter_output)
   endtask

   // software strobe: timing, software retrigger, gate pause
   task automatic t_mode4();
      host.setup(MODE_SWSTB, 8'h02);
      @(posedge clk);
      `check("out m4", 1'b1, counter_output)
      pulses(2);
      `check("out m4", 1'b1, counter_output)
      pulses(1);
      `check("strobe", 1'b0, counter_output)
      pulses(1);
      `check("out m4", 1'b1, counter_output)
      host.wr(OFF_COUNT, 8'h02);
      pulses(2);
      host.wr(OFF_COUNT, 8'h03);
      pulses(1);
      host.rd(OFF_CE_LO, d);
      `check("ce m4", 8'h03, d)
      pulses(2);
      `check("out m4", 1'b1, counter_output)
      pulses(1);
      `check("strobe", 1'b0, counter_output)
      @(posedge clk) gate_input <= 1'b0;
      host.wr(OFF_COUNT, 8'h02);
      pulses(5);
      `check("out m4 gated", 1'b1, counter_output)
      @(posedge clk) gate_input <= 1'b1;
   endtask

   // hardware strobe: waits for trigger, N+1 after it, reload
   task automatic t_mode5();
      host.setup(MODE_HWSTB, 8'h02);
      pulses(4);
      `check("out m5 idle", 1'b1, counter_output)
      trigger();
      pulses(2);
      `check("out m5", 1'b1, counter_output)
      pulses(1);
      `check("strobe", 1'b0, counter_output)
      pulses(1);
      `check("out m5", 1'b1, counter_output)
      host.wr(OFF_COUNT, 8'h04);
      trigger();
      pulses(1);
      host.rd(OFF_CE_LO, d);
      `check("ce m5", 8'h04, d)
   endtask

   // one-shot: N-pulse low, retrigger stretches, new count at trigger
   task automatic t_mode1();
      host.setup(MODE_ONESHOT, 8'h03);
      @(posedge clk);
      `check("out m1", 1'b1, counter_output)
      trigger();
      pulses(1);
      `check("out m1", 1'b0, counter_output)
      pulses(2);
      `check("out m1", 1'b0, counter_output)
      pulses(1);
      `check("out m1", 1'b1, counter_output)
      host.wr(OFF_COUNT, 8'h05);
      pulses(2);
      `check("out m1", 1'b1, counter_output)
      trigger();
      pulses(2);
      trigger();
      pulses(5);
      `check("out m1", 1'b0, counter_output)
      pulses(1);
      `check("out m1", 1'b1, counter_output)
   endtask

   // rate generator: one low per N, gate forces high, trigger resync
   task automatic t_mode2();
      host.setup(MODE_RATE, 8'h03);
      @(posedge clk);
      `check("out m2", 1'b1, counter_output)
      pulses(1);
      lows(9, 3);
      pulses(2);
      `check("out m2 low", 1'b0, counter_output)
      @(posedge clk) gate_input <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      `check("out m2 gated", 1'b1, counter_output)
      lows(6, 0);
      trigger();
      lows(9, 3);
      pulses(1);
      host.wr(OFF_COUNT, 8'h04);
      lows(2, 1);
      lows(8, 2);
   endtask

   // square wave: even and odd duty
   task automatic t_mode3();
      host.setup(MODE_SQUARE, 8'h04);
      @(posedge clk);
      `check("out m3", 1'b1, counter_output)
      pulses(1);
      lows(8, 4);
      host.setup(MODE_SQUARE, 8'h05);
      pulses(1);
      lows(10, 4);
   endtask

   // two-byte and high-only formats, folded mode, latch command
   task automatic t_bytes();
      host.wr(OFF_CTRL, 8'h30);
      host.wr(OFF_COUNT, 8'h02);
      host.wr(OFF_COUNT, 8'h01);
      pulses(1);
      host.rd(OFF_CE_HI, d);
      `check("ce high both", 8'h01, d)
      host.rd(OFF_CE_LO, d);
      `check("ce low both", 8'h02, d)
      host.wr(OFF_CTRL, 8'h2c);
      host.rd(OFF_STATUS, d);
      `check("status folded", 8'he4, d)
      host.wr(OFF_CTRL, 8'h02);
      host.rd(OFF_STATUS, d);
      `check("status latch cmd", 8'he4, d)
      host.wr(OFF_COUNT, 8'h01);
      pulses(1);
      host.rd(OFF_CE_HI, d);
      `check("ce high only", 8'h01, d)
   endtask

   // ****************************************
   // verdict and main sequence
   // ****************************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // watchdog: run needs about 480 cycles, allow 5000
   initial begin
      #50000;
      n_errors++;
      close_out();
   end

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_mode0();
      t_gate0();
      t_mode4();
      t_mode5();
      t_mode1();
      t_mode2();
      t_mode3();
      t_bytes();
      close_out();
   end
endmodule
